// *** design/point_alarm_status_evaluator.sv ***
// Alarm and warning status evaluator for one binary and one analog input point
`timescale 1ns/1ps
`include "point_alarm_consts.svh"
module point_alarm_status_evaluator #(
  parameter int W = 16
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  input  wire logic                 binIn,
  input  wire logic                 binReliable,
  input  wire logic                 binOverride,
  input  wire logic                 anReliable,
  input  wire logic                 anOverride,
  input  wire logic [W-1:0]         lowAlarmLvl,
  input  wire logic [W-1:0]         lowWarnLvl,
  input  wire logic [W-1:0]         highWarnLvl,
  input  wire logic [W-1:0]         highAlarmLvl,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic                      irq
);
  import point_alarm_pkg::*;

  // ************************************************
  // State
  // ************************************************
  typedef struct packed {
    logic [1:0]         binSync;
    logic [W-1:0]       anValue;
    point_alarm_pkg::byte_t binCfg;
    point_alarm_pkg::byte_t binSt;
    point_alarm_pkg::byte_t anCfg;
    point_alarm_pkg::byte_t anSt;
    logic               binLastRep;
    logic [2:0]         anLastRep;
    logic [1:0]         chgPend;
    logic [`IRQ_BITS-1:0] irqSt;
    logic [`IRQ_BITS-1:0] irqMask;
    logic               awHeld;
    logic [7:0]         awAddr;
    logic               wHeld;
    logic [31:0]        wData;
    logic [3:0]         wStrb;
    logic               bValid;
    logic [1:0]         bResp;
    logic               rValid;
    logic [31:0]        rData;
    logic [1:0]         rResp;
    logic               irqOut;
  } state_s;

  state_s st_ff;
  state_s nxt_st;
  region_code_e regionCode;
  logic         binCur;

  region_encoder #(.W(W)) u_enc (
    .value     (st_ff.anValue),
    .lowAlarm  (lowAlarmLvl),
    .lowWarn   (lowWarnLvl),
    .highWarn  (highWarnLvl),
    .highAlarm (highAlarmLvl),
    .code      (regionCode)
  );

  assign binCur = st_ff.binSync[1];

  // ************************************************
  // Next state
  // ************************************************
  // Bus, command decode and evaluation in one pass
  always_comb begin
    logic        doWrite;
    logic        rdBin;
    logic        rdAn;
    logic        poll;
    logic        binAlarm;
    logic [2:0]  anCode;
    logic        evalEv;
    logic        chgEv;
    logic [31:0] wd;
    logic [`IRQ_BITS-1:0] setIrq;
    logic [`IRQ_BITS-1:0] clrIrq;
    doWrite  = 1'b0;
    rdBin    = 1'b0;
    rdAn     = 1'b0;
    poll     = 1'b0;
    binAlarm = 1'b0;
    anCode   = 3'h0;
    evalEv   = 1'b0;
    chgEv    = 1'b0;
    wd       = 32'h0;
    setIrq   = '0;
    clrIrq   = '0;
    nxt_st   = st_ff;
    // Pin input passes two flops before use
    nxt_st.binSync = {st_ff.binSync[0], binIn};
    // Write address and data accepted in either order
    if (s_axi_awvalid && !st_ff.awHeld) begin
      nxt_st.awHeld = 1'b1;
      nxt_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_ff.wHeld) begin
      nxt_st.wHeld = 1'b1;
      nxt_st.wData = s_axi_wdata;
      nxt_st.wStrb = s_axi_wstrb;
    end
    if (st_ff.awHeld && st_ff.wHeld && !st_ff.bValid) begin
      doWrite = 1'b1;
      nxt_st.awHeld = 1'b0;
      nxt_st.wHeld  = 1'b0;
      nxt_st.bValid = 1'b1;
      nxt_st.bResp  = 2'h0;
      wd = st_ff.wData;
      // Only the low byte lane carries config data; the analog input takes wd[W-1:0]
      unique case (st_ff.awAddr)
        `OFS_BIN_CONFIG: if (st_ff.wStrb[0]) nxt_st.binCfg = wd[7:0];
        `OFS_AN_CONFIG:  if (st_ff.wStrb[0]) nxt_st.anCfg = wd[7:0];
        `OFS_AN_INPUT:   nxt_st.anValue = wd[W-1:0];
        `OFS_CMD: begin
          rdBin = wd[`CMD_READ_BIN_BIT];
          rdAn  = wd[`CMD_READ_AN_BIT];
          poll  = wd[`CMD_POLL_BIT];
        end
        `OFS_IRQ_STATUS: clrIrq = wd[`IRQ_BITS-1:0];
        `OFS_IRQ_MASK:   nxt_st.irqMask = wd[`IRQ_BITS-1:0];
        `OFS_BIN_STATUS, `OFS_AN_STATUS, `OFS_CHG_PENDING: ;
        default: nxt_st.bResp = 2'h2;
      endcase
    end
    if (st_ff.bValid && s_axi_bready) begin
      nxt_st.bValid = 1'b0;
    end
    // Evaluation on read command or change poll; a poll checks enabled points
    binAlarm = (binCur != st_ff.binCfg[`CFG_NORMAL_BIT]) &&
               st_ff.binCfg[`CFG_ALARM_EN_BIT];
    anCode = (st_ff.anCfg[`CFG_WARN_EN_BIT] && st_ff.anCfg[`CFG_ALARM_EN_BIT]) ?
             regionCode : REG_NORMAL;
    if (rdBin || (poll && st_ff.binCfg[`CFG_CHG_EN_BIT])) begin
      evalEv = 1'b1;
      nxt_st.binSt = 8'h00;
      nxt_st.binSt[`ST_CURRENT_BIT]  = binCur;
      nxt_st.binSt[`ST_ALARM_BIT]    = binAlarm;
      nxt_st.binSt[`ST_OVERRIDE_BIT] = binOverride;
      nxt_st.binSt[`ST_RELIABLE_BIT] = binReliable;
    end
    if (rdAn || (poll && st_ff.anCfg[`CFG_CHG_EN_BIT])) begin
      evalEv = 1'b1;
      nxt_st.anSt = 8'h00;
      nxt_st.anSt[`ST_CODE_LSB +: 3]  = anCode;
      nxt_st.anSt[`ST_OVERRIDE_BIT]  = anOverride;
      nxt_st.anSt[`ST_RELIABLE_BIT]  = anReliable;
    end
    // Each poll reports only changes since the last report
    nxt_st.chgPend = 2'h0;
    if (poll) begin
      if (st_ff.binCfg[`CFG_CHG_EN_BIT] && binCur != st_ff.binLastRep) begin
        nxt_st.chgPend[0]  = 1'b1;
        nxt_st.binLastRep  = binCur;
      end
      if (st_ff.anCfg[`CFG_CHG_EN_BIT] && anCode != st_ff.anLastRep) begin
        nxt_st.chgPend[1]  = 1'b1;
        nxt_st.anLastRep   = anCode;
      end
      chgEv = nxt_st.chgPend != 2'h0;
    end else begin
      nxt_st.chgPend = st_ff.chgPend;
    end
    // Sticky flags: a new event wins over a same-cycle clear
    setIrq[`IRQ_EVAL_BIT]   = evalEv;
    setIrq[`IRQ_CHANGE_BIT] = chgEv;
    nxt_st.irqSt  = (st_ff.irqSt & ~clrIrq) | setIrq;
    nxt_st.irqOut = (nxt_st.irqSt & nxt_st.irqMask) != '0;
    // Read channel; one read outstanding
    if (st_ff.rValid && s_axi_rready) begin
      nxt_st.rValid = 1'b0;
    end
    if (s_axi_arvalid && !st_ff.rValid) begin
      nxt_st.rValid = 1'b1;
      nxt_st.rResp  = 2'h0;
      nxt_st.rData  = 32'h0;
      unique case (s_axi_araddr)
        `OFS_BIN_CONFIG:  nxt_st.rData[7:0] = st_ff.binCfg;
        `OFS_BIN_STATUS:  nxt_st.rData[7:0] = st_ff.binSt;
        `OFS_AN_CONFIG:   nxt_st.rData[7:0] = st_ff.anCfg;
        `OFS_AN_STATUS:   nxt_st.rData[7:0] = st_ff.anSt;
        `OFS_AN_INPUT:    nxt_st.rData[W-1:0] = st_ff.anValue;
        `OFS_CMD:         ;
        `OFS_IRQ_STATUS:  nxt_st.rData[`IRQ_BITS-1:0] = st_ff.irqSt;
        `OFS_IRQ_MASK:    nxt_st.rData[`IRQ_BITS-1:0] = st_ff.irqMask;
        `OFS_CHG_PENDING: nxt_st.rData[1:0] = st_ff.chgPend;
        default:          nxt_st.rResp = 2'h2;
      endcase
    end
  end

  // ************************************************
  // Registers
  // ************************************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Ready only while the holding slot is empty
  assign s_axi_awready = !st_ff.awHeld;
  assign s_axi_wready  = !st_ff.wHeld;
  assign s_axi_arready = !st_ff.rValid;
  assign s_axi_bvalid  = st_ff.bValid;
  assign s_axi_bresp   = st_ff.bResp;
  assign s_axi_rvalid  = st_ff.rValid;
  assign s_axi_rdata   = st_ff.rData;
  assign s_axi_rresp   = st_ff.rResp;
  assign irq           = st_ff.irqOut;

  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  bin_alarm_gate_a: assert property (
    (st_ff.binSt[`ST_ALARM_BIT] && $changed(st_ff.binSt)) |->
      $past(st_ff.binCfg[`CFG_ALARM_EN_BIT]))
    else $error("binary alarm raised while disabled");
  bin_alarm_diff_a: assert property (
    $changed(st_ff.binSt) && $past(st_ff.binCfg[`CFG_ALARM_EN_BIT]) |->
      st_ff.binSt[`ST_ALARM_BIT] ==
      (st_ff.binSt[`ST_CURRENT_BIT] != $past(st_ff.binCfg[`CFG_NORMAL_BIT])))
    else $error("binary alarm not current versus normal");
  bin_alarm_off_a: assert property (
    (!st_ff.binCfg[`CFG_ALARM_EN_BIT] && $stable(st_ff.binCfg)) [*2] |->
      !st_ff.binSt[`ST_ALARM_BIT] || $stable(st_ff.binSt))
    else $error("alarm bit set with alarm disabled");
  an_code_legal_a: assert property (
    st_ff.anSt[6:4] inside {3'h0, 3'h3, 3'h4, 3'h5, 3'h6})
    else $error("illegal region code");
  an_code_gate_a: assert property (
    $changed(st_ff.anSt) && !$past(st_ff.anCfg[`CFG_WARN_EN_BIT]) |->
      st_ff.anSt[6:4] == 3'h0)
    else $error("region code without enables");
  eval_on_cmd_a: assert property (
    $changed(st_ff.binSt) |-> $past(st_ff.awHeld && st_ff.wHeld &&
      st_ff.awAddr == `OFS_CMD))
    else $error("evaluation without command");
  bin_status_bit_a: assert property (
    st_ff.binSt[7] == 1'b0 && st_ff.binSt[5] == 1'b0 && st_ff.binSt[3:2] == 2'h0)
    else $error("binary status reserved bit set");
  change_once_a: assert property (
    $past(st_ff.awHeld && st_ff.wHeld && !st_ff.bValid && st_ff.awAddr == `OFS_CMD &&
      st_ff.wData[`CMD_POLL_BIT] && st_ff.binCfg[`CFG_CHG_EN_BIT]) |->
      st_ff.chgPend[0] == ($past(binCur) != $past(st_ff.binLastRep)))
    else $error("change reported twice");
  irq_level_a: assert property (
    irq == ((st_ff.irqSt & st_ff.irqMask) != '0))
    else $error("interrupt level wrong");
  resp_after_write_a: assert property (
    st_ff.awHeld && st_ff.wHeld && !st_ff.bValid |=> s_axi_bvalid)
    else $error("write response missing");

  poll_cov_c:  cover property (st_ff.chgPend != 2'h0);
  alarm_cov_c: cover property (st_ff.binSt[`ST_ALARM_BIT]);
  high_cov_c:  cover property (st_ff.anSt[6:4] == 3'h6);
  irq_cov_c:   cover property (irq);
endmodule

// *** design/point_alarm_consts.svh ***
// Register offsets, field positions and reset values of the point alarm evaluator
`ifndef POINT_ALARM_CONSTS_SVH
`define POINT_ALARM_CONSTS_SVH
`define OFS_BIN_CONFIG      8'h00
`define OFS_BIN_STATUS      8'h04
`define OFS_AN_CONFIG       8'h08
`define OFS_AN_STATUS       8'h0c
`define OFS_AN_INPUT        8'h10
`define OFS_CMD             8'h14
`define OFS_IRQ_STATUS      8'h18
`define OFS_IRQ_MASK        8'h1c
`define OFS_CHG_PENDING     8'h20
`define CFG_CHG_EN_BIT      0
`define CFG_NORMAL_BIT      1
`define CFG_ALARM_EN_BIT    3
`define CFG_WARN_EN_BIT     4
`define ST_RELIABLE_BIT     0
`define ST_OVERRIDE_BIT     1
`define ST_ALARM_BIT        4
`define ST_CURRENT_BIT      6
`define ST_CODE_LSB         4
`define CMD_READ_BIN_BIT    0
`define CMD_READ_AN_BIT     1
`define CMD_POLL_BIT        2
`define CFG_RESET           8'h00
`define IRQ_EVAL_BIT        0
`define IRQ_CHANGE_BIT      1
`define IRQ_BITS            2
`endif

// *** design/point_alarm_pkg.sv ***
// Types shared by the point alarm evaluator
package point_alarm_pkg;
  // Analog input region code values
  typedef enum logic [2:0] {
    REG_NORMAL    = 3'h0,
    REG_LOW_WARN  = 3'h3,
    REG_LOW_ALARM = 3'h4,
    REG_HIGH_WARN = 3'h5,
    REG_HIGH_ALARM = 3'h6
  } region_code_e;
  typedef logic [7:0] byte_t;
endpackage

// *** design/region_encoder.sv ***
// Combinational encoder from analog value and thresholds to region code
`timescale 1ns/1ps
module region_encoder #(
  parameter int W = 16
) (
  input  wire logic [W-1:0]                     value,
  input  wire logic [W-1:0]                     lowAlarm,
  input  wire logic [W-1:0]                     lowWarn,
  input  wire logic [W-1:0]                     highWarn,
  input  wire logic [W-1:0]                     highAlarm,
  output point_alarm_pkg::region_code_e         code
);
  import point_alarm_pkg::*;
  // Alarm regions win over warning regions; thresholds are inclusive
  always_comb begin
    if (value >= highAlarm) begin
      code = REG_HIGH_ALARM;
    end else if (value <= lowAlarm) begin
      code = REG_LOW_ALARM;
    end else if (value >= highWarn) begin
      code = REG_HIGH_WARN;
    end else if (value <= lowWarn) begin
      code = REG_LOW_WARN;
    end else begin
      code = REG_NORMAL;
    end
  end
endmodule

// *** verification/axi_poller_model.sv ***
// Register bus master standing in for the network poller
`timescale 1ns/1ps
module axi_poller_model (
  input  wire logic        ref_clk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // Idle bus from time zero
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    wstrb = 4'hf;
  end

  // Write: offer both channels, drop each when taken, wait as long as the slave needs
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  // Read: rready stays up until the data beat is sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
endmodule

// *** verification/tb_top.sv ***
// Self-checking testbench of the point alarm status evaluator
`timescale 1ns/1ps
`include "point_alarm_consts.svh"
module tb_top;
  import point_alarm_pkg::*;
  logic         ref_clk     = 1'b0;
  logic         rstn        = 1'b0;
  logic         binIn       = 1'b0;
  logic         binReliable = 1'b1;
  logic         binOverride = 1'b1;
  logic         anOverride  = 1'b0;
  logic [7:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata;
  logic [3:0]   wstrb;
  logic [1:0]   bresp, rresp;
  logic         awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready, irq;
  int           errors      = 0;
  int           n_compared  = 0;
  logic [15:0]  anVal [5]   = '{16'd500, 16'd200, 16'd100, 16'd800, 16'd900};
  region_code_e anCode [5]  = '{REG_NORMAL, REG_LOW_WARN, REG_LOW_ALARM, REG_HIGH_WARN,
                                REG_HIGH_ALARM};
  logic [7:0]   bCfg [4]    = '{8'h08, 8'h0a, 8'h00, 8'h0a};
  logic         bIn [4]     = '{1'b1, 1'b1, 1'b1, 1'b0};
  logic [7:0]   bExp [4]    = '{8'h53, 8'h43, 8'h43, 8'h13};

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  // Thresholds are fixed so that each warning and alarm region has a boundary value in the table
  point_alarm_status_evaluator point_alarm_status_evaluator_inst (
    .ref_clk(ref_clk), .rstn(rstn), .binIn(binIn), .binReliable(binReliable),
    .binOverride(binOverride), .anReliable(1'b1), .anOverride(anOverride),
    .lowAlarmLvl(16'd100), .lowWarnLvl(16'd200), .highWarnLvl(16'd800),
    .highAlarmLvl(16'd900), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));

  axi_poller_model axi_poller_model_inst (
    .ref_clk(ref_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // ***********************************************************
  // Checking and bus helpers
  // ***********************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] r;
    axi_poller_model_inst.wr(a, d, r);
    chk({30'h0, r}, {30'h0, e});
  endtask

  // Read data is only compared when an OKAY answer is expected; error beats carry all-zero data
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_poller_model_inst.rd(a, d, r);
    if (er == 2'h0) chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask

  // Input pin goes through a two-flop synchroniser, so give it time to land
  task automatic idle();
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic stop_test();
    if (errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #200000;
    errors++;
    stop_test();
  end

  // ***********************************************************
  // Test sequence
  // ***********************************************************
  initial begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    rdc(`OFS_BIN_CONFIG, 32'h0, 2'h0);
    rdc(`OFS_IRQ_MASK, 32'h0, 2'h0);
    rdc(8'h24, 32'h0, 2'h2);
    wrc(8'h24, 32'h1, 2'h2);
    // Analog regions, boundaries included, with both enables set
    wrc(`OFS_AN_CONFIG, 32'h18, 2'h0);
    for (int i = 0; i < 5; i++) begin
      wrc(`OFS_AN_INPUT, {16'h0, anVal[i]}, 2'h0);
      wrc(`OFS_CMD, 32'h2, 2'h0);
      rdc(`OFS_AN_STATUS, {25'h0, anCode[i], 4'h1}, 2'h0);
    end
    wrc(`OFS_AN_CONFIG, 32'h08, 2'h0);
    @(posedge ref_clk);
    anOverride <= 1'b1;
    wrc(`OFS_CMD, 32'h2, 2'h0);
    rdc(`OFS_AN_STATUS, 32'h03, 2'h0);
    // Binary alarm against normal state and enable
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      binIn <= bIn[i];
      idle();
      wrc(`OFS_BIN_CONFIG, {24'h0, bCfg[i]}, 2'h0);
      wrc(`OFS_CMD, 32'h1, 2'h0);
      rdc(`OFS_BIN_STATUS, {24'h0, bExp[i]}, 2'h0);
    end
    // No evaluation without a command; status is read-only
    @(posedge ref_clk);
    binIn <= 1'b1;
    idle();
    wrc(`OFS_BIN_STATUS, 32'hff, 2'h0);
    rdc(`OFS_BIN_STATUS, 32'h13, 2'h0);
    // Change poll reports a change once
    wrc(`OFS_BIN_CONFIG, 32'h01, 2'h0);
    wrc(`OFS_CMD, 32'h4, 2'h0);
    wrc(`OFS_CMD, 32'h4, 2'h0);
    rdc(`OFS_CHG_PENDING, 32'h0, 2'h0);
    @(posedge ref_clk);
    binIn <= 1'b0;
    idle();
    wrc(`OFS_CMD, 32'h4, 2'h0);
    rdc(`OFS_CHG_PENDING, 32'h1, 2'h0);
    rdc(`OFS_BIN_STATUS, 32'h03, 2'h0);
    wrc(`OFS_CMD, 32'h4, 2'h0);
    rdc(`OFS_CHG_PENDING, 32'h0, 2'h0);
    // Analog point joins the poll and reports its region once
    wrc(`OFS_AN_CONFIG, 32'h19, 2'h0);
    wrc(`OFS_CMD, 32'h4, 2'h0);
    rdc(`OFS_CHG_PENDING, 32'h2, 2'h0);
    rdc(`OFS_AN_STATUS, 32'h63, 2'h0);
    wrc(`OFS_CMD, 32'h4, 2'h0);
    rdc(`OFS_CHG_PENDING, 32'h0, 2'h0);
    // Interrupt: clear, raise while masked, unmask, clear again
    rdc(`OFS_IRQ_STATUS, 32'h3, 2'h0);
    wrc(`OFS_IRQ_STATUS, 32'h3, 2'h0);
    rdc(`OFS_IRQ_STATUS, 32'h0, 2'h0);
    wrc(`OFS_CMD, 32'h1, 2'h0);
    idle();
    rdc(`OFS_IRQ_STATUS, 32'h1, 2'h0);
    chk({31'h0, irq}, 32'h0);
    wrc(`OFS_IRQ_MASK, 32'h1, 2'h0);
    idle();
    chk({31'h0, irq}, 32'h1);
    wrc(`OFS_IRQ_STATUS, 32'h1, 2'h0);
    idle();
    chk({31'h0, irq}, 32'h0);
    rdc(`OFS_IRQ_STATUS, 32'h0, 2'h0);
    stop_test();
  end
endmodule
